// >>> src/ecpc_pkg.sv
package ecpc_pkg;

  // ==========================================================================
  // Framing bytes
  localparam logic [7:0]  BYTE_DLE      = 8'h10;
  localparam logic [7:0]  BYTE_ETX      = 8'h03;
  localparam logic [7:0]  BYTE_PKT_ID   = 8'h91;
  localparam logic [7:0]  SUB_EVT_CAP   = 8'h07;
  localparam logic [7:0]  SUB_POS_INFO  = 8'h08;
  localparam logic [7:0]  BYTE_KEEP     = 8'hff;
  localparam logic [7:0]  BYTE_ZERO     = 8'h00;
  localparam logic [31:0] OFFSET_KEEP   = 32'hffffffff;

  // ==========================================================================
  // Modes and field values
  localparam logic [7:0]  MODE_QUERY    = 8'h00;
  localparam logic [7:0]  MODE_SET      = 8'h01;
  localparam logic [7:0]  MODE_RESP     = 8'h02;
  localparam logic [7:0]  CAP_DISABLE   = 8'h00;
  localparam logic [7:0]  CAP_ENABLE    = 8'h01;
  localparam logic [7:0]  CNT_CLEAR     = 8'h01;

  // ==========================================================================
  // Lengths and body indices (index 0 is the mode byte)
  localparam logic [15:0] LEN_QUERY     = 16'h0002;
  localparam logic [15:0] LEN_EC_SET    = 16'h000c;
  localparam logic [15:0] LEN_POS_SET   = 16'h0003;
  localparam logic [15:0] LEN_ONE       = 16'h0001;
  localparam logic [15:0] IDX_MODE      = 16'h0000;
  localparam logic [15:0] IDX_FIELD     = 16'h0001;
  localparam logic [15:0] IDX_OFF_FIRST = 16'h0002;
  localparam logic [15:0] IDX_OFF_LAST  = 16'h0005;
  localparam logic [15:0] IDX_CLEAR     = 16'h0006;
  localparam logic [7:0]  LEN_EC_RESP   = 8'h0b;
  localparam logic [7:0]  LEN_POS_RESP  = 8'h03;

  // ==========================================================================
  // Response byte positions
  localparam logic [4:0]  TX_EC_LAST    = 5'h11;
  localparam logic [4:0]  TX_POS_LAST   = 5'h09;
  localparam logic [4:0]  TX_EC_CKS     = 5'h0f;
  localparam logic [4:0]  TX_POS_CKS    = 5'h07;
  localparam logic [4:0]  TX_ONE        = 5'h01;

  // ==========================================================================
  // Reset values and widths
  localparam int          EVT_CNT_W     = 16;
  localparam logic        RST_CAP_EN    = 1'b0;
  localparam logic [31:0] RST_OFFSET    = 32'h00000000;
  localparam logic [3:0]  RST_POS_MASK  = 4'h0;

  typedef struct packed {
    logic [7:0]  sub;
    logic        cap_en;
    logic [31:0] offset;
    logic [3:0]  mask;
  } ecpc_resp_t;

  typedef struct packed {
    logic [31:0]          time_ns;
    logic [EVT_CNT_W-1:0] count;
  } ecpc_evt_t;

  typedef enum logic [2:0] {
    RX_IDLE = 3'b000,
    RX_PID  = 3'b001,
    RX_SUB  = 3'b010,
    RX_LENH = 3'b011,
    RX_LENL = 3'b100,
    RX_BODY = 3'b101,
    RX_DLE1 = 3'b110,
    RX_DLE2 = 3'b111
  } ecpc_rx_state_t;

endpackage : ecpc_pkg

// >>> src/ecpc_top.sv
`timescale 1ns/1ps
`default_nettype none
module ecpc_top (
  input  wire logic                 i_clk,
  input  wire logic                 i_reset_n,
  input  wire logic [7:0]           i_rx_byte,
  input  wire logic                 i_rx_valid,
  output logic                      o_rx_ready,
  output logic [7:0]                o_tx_byte,
  output logic                      o_tx_valid,
  input  wire logic                 i_tx_ready,
  input  wire logic                 i_event,
  input  wire logic [31:0]          i_time_ns,
  output logic                      o_evt_valid,
  output ecpc_pkg::ecpc_evt_t       o_evt,
  output logic                      o_capture_en,
  output logic [31:0]               o_offset_ns,
  output logic [3:0]                o_pos_mask
);
  import ecpc_pkg::*;

  // ==========================================================================
  // State
  ecpc_rx_state_t       state_ff;
  ecpc_rx_state_t       nxt_state;
  logic [7:0]           sub_ff;
  logic [15:0]          len_ff;
  logic [15:0]          cnt_ff;
  logic [7:0]           acc_ff;
  logic [7:0]           mode_ff;
  logic [7:0]           field_ff;
  logic [31:0]          off_in_ff;
  logic [7:0]           clr_ff;
  logic                 cap_en_ff;
  logic [31:0]          offset_ff;
  logic [3:0]           mask_ff;
  logic                 start_ff;
  logic                 event_prev_ff;
  logic                 evt_valid_ff;
  ecpc_evt_t            evt_ff;
  logic [EVT_CNT_W-1:0] count_ff;
  logic                 tx_busy;

  // ==========================================================================
  // Receive handshake
  wire logic accept  = i_rx_valid & o_rx_ready;
  wire logic is_dle  = (i_rx_byte == BYTE_DLE);
  wire logic body_lt = (cnt_ff == len_ff - LEN_ONE);

  assign o_rx_ready = ~tx_busy & ~start_ff;

  always_comb begin
    nxt_state = state_ff;
    if (accept) begin
      unique case (state_ff)
        RX_IDLE: nxt_state = is_dle ? RX_PID : RX_IDLE;
        RX_PID:  nxt_state = (i_rx_byte == BYTE_PKT_ID) ? RX_SUB : RX_IDLE;
        RX_SUB:  nxt_state = RX_LENH;
        RX_LENH: nxt_state = RX_LENL;
        RX_LENL: nxt_state = ({len_ff[15:8], i_rx_byte} == 16'h0000) ? RX_IDLE : RX_BODY;
        RX_BODY: nxt_state = body_lt ? RX_DLE1 : RX_BODY;
        RX_DLE1: nxt_state = is_dle ? RX_DLE2 : RX_IDLE;
        RX_DLE2: nxt_state = RX_IDLE;
      endcase
    end
  end

  // ==========================================================================
  // Packet decode
  wire logic pkt_done = accept & (state_ff == RX_DLE2);
  wire logic cks_ok   = (acc_ff == BYTE_ZERO);
  wire logic frame_ok = pkt_done & (i_rx_byte == BYTE_ETX) & cks_ok;
  wire logic is_ec    = (sub_ff == SUB_EVT_CAP);
  wire logic is_pos   = (sub_ff == SUB_POS_INFO);
  wire logic is_query = (mode_ff == MODE_QUERY) & (len_ff == LEN_QUERY);
  wire logic ec_set   = is_ec & (mode_ff == MODE_SET) & (len_ff == LEN_EC_SET);
  wire logic pos_set  = is_pos & (mode_ff == MODE_SET) & (len_ff == LEN_POS_SET) & (field_ff[7:4] == 4'h0);
  wire logic do_ec    = frame_ok & ec_set;
  wire logic do_pos   = frame_ok & pos_set;
  // Unknown subpackets, responses from the host and bad lengths fall through
  wire logic do_resp  = frame_ok & (((is_ec | is_pos) & is_query) | ec_set | pos_set);

  wire logic nxt_cap_en = (do_ec && field_ff == CAP_ENABLE)  ? 1'b1 :
                          (do_ec && field_ff == CAP_DISABLE) ? 1'b0 : cap_en_ff;
  wire logic [31:0] nxt_offset = (do_ec && off_in_ff != OFFSET_KEEP) ? off_in_ff : offset_ff;
  wire logic [3:0]  nxt_mask   = do_pos ? field_ff[3:0] : mask_ff;
  wire logic [7:0]  nxt_acc    = (state_ff == RX_IDLE) ? BYTE_ZERO :
                                 (state_ff == RX_PID || state_ff == RX_SUB || state_ff == RX_LENH ||
                                  state_ff == RX_LENL || state_ff == RX_BODY) ? (acc_ff ^ i_rx_byte) : acc_ff;

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_ff <= RX_IDLE;
      acc_ff   <= BYTE_ZERO;
    end else begin
      state_ff <= nxt_state;
      if (accept) acc_ff <= nxt_acc;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sub_ff <= BYTE_ZERO;
      len_ff <= 16'h0000;
      cnt_ff <= 16'h0000;
    end else if (accept) begin
      if (state_ff == RX_SUB) sub_ff <= i_rx_byte;
      if (state_ff == RX_LENH) len_ff <= {i_rx_byte, BYTE_ZERO};
      if (state_ff == RX_LENL) len_ff <= {len_ff[15:8], i_rx_byte};
      cnt_ff <= (state_ff == RX_BODY) ? cnt_ff + LEN_ONE : 16'h0000;
    end
  end

  // ==========================================================================
  // Body field capture; reserved bytes are skipped
  wire logic in_body = accept & (state_ff == RX_BODY);

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      mode_ff   <= BYTE_KEEP;
      field_ff  <= BYTE_KEEP;
      off_in_ff <= OFFSET_KEEP;
      clr_ff    <= BYTE_KEEP;
    end else if (in_body) begin
      if (cnt_ff == IDX_MODE) mode_ff <= i_rx_byte;
      if (cnt_ff == IDX_FIELD) field_ff <= i_rx_byte;
      if (cnt_ff >= IDX_OFF_FIRST && cnt_ff <= IDX_OFF_LAST) off_in_ff <= {off_in_ff[23:0], i_rx_byte};
      if (cnt_ff == IDX_CLEAR) clr_ff <= i_rx_byte;
    end
  end

  // ==========================================================================
  // Configuration
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cap_en_ff <= RST_CAP_EN;
      offset_ff <= RST_OFFSET;
      mask_ff   <= RST_POS_MASK;
      start_ff  <= 1'b0;
    end else begin
      cap_en_ff <= nxt_cap_en;
      offset_ff <= nxt_offset;
      mask_ff   <= nxt_mask;
      start_ff  <= do_resp;
    end
  end

  // ==========================================================================
  // Event capture
  wire logic ev_edge  = i_event & ~event_prev_ff;
  wire logic ev_take  = ev_edge & cap_en_ff;
  wire logic cnt_clr  = do_ec & (clr_ff == CNT_CLEAR);
  // A clear in the same cycle as an event still counts the event
  wire logic [EVT_CNT_W-1:0] nxt_count = cnt_clr ? EVT_CNT_W'(ev_take) : count_ff + EVT_CNT_W'(ev_take);
  wire logic [31:0] ev_time = 32'(i_time_ns + offset_ff);

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      event_prev_ff <= 1'b0;
      evt_valid_ff  <= 1'b0;
      evt_ff        <= '0;
      count_ff      <= '0;
    end else begin
      event_prev_ff <= i_event;
      evt_valid_ff  <= ev_take;
      count_ff      <= nxt_count;
      if (ev_take) evt_ff <= '{time_ns: ev_time, count: nxt_count};
    end
  end

  // ==========================================================================
  // Response transmitter
  wire ecpc_resp_t resp = '{sub: sub_ff, cap_en: cap_en_ff, offset: offset_ff, mask: mask_ff};

  ecpc_tx u_tx (
    .i_clk      (i_clk),
    .i_reset_n  (i_reset_n),
    .i_start    (start_ff),
    .i_resp     (resp),
    .i_tx_ready (i_tx_ready),
    .o_tx_byte  (o_tx_byte),
    .o_tx_valid (o_tx_valid),
    .o_busy     (tx_busy)
  );

  assign o_evt_valid  = evt_valid_ff;
  assign o_evt        = evt_ff;
  assign o_capture_en = cap_en_ff;
  assign o_offset_ns  = offset_ff;
  assign o_pos_mask   = mask_ff;

  // ==========================================================================
  // Checks
  AST_EVT_WHEN_EN: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (ev_edge && cap_en_ff) |=> (o_evt_valid && o_evt.time_ns == $past(i_time_ns) + $past(offset_ff)))
    else $error("Captured edge gave no report");
  AST_NO_EVT_DIS: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    !(ev_edge && cap_en_ff) |=> !o_evt_valid) else $error("Report without enabled edge");
  AST_CAP_KEEP: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (do_ec && field_ff == BYTE_KEEP) |=> $stable(o_capture_en)) else $error("Capture state changed on keep");
  AST_CAP_SET: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (do_ec && field_ff[7:1] == 7'h00) |=> (o_capture_en == $past(field_ff[0]))) else $error("Capture state not set");
  AST_OFF_SET: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (do_ec && off_in_ff != OFFSET_KEEP) |=> (o_offset_ns == $past(off_in_ff))) else $error("Offset not stored");
  AST_CNT_CLR: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (cnt_clr && !ev_take) |=> (count_ff == '0)) else $error("Event count not cleared");
  AST_MASK_SET: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    do_pos |=> (o_pos_mask == $past(field_ff[3:0]))) else $error("Position mask not stored");
  AST_BAD_NOCHG: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (pkt_done && !cks_ok) |=> ($stable(o_pos_mask) && $stable(o_offset_ns) && $stable(o_capture_en)))
    else $error("Bad packet changed configuration");
  AST_RESP_SOON: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    do_resp |-> ##[2:3] (o_tx_valid && o_tx_byte == BYTE_DLE)) else $error("No response started");
endmodule : ecpc_top
`default_nettype wire

// >>> src/ecpc_tx.sv
`timescale 1ns/1ps
`default_nettype none
module ecpc_tx (
  input  wire logic               i_clk,
  input  wire logic               i_reset_n,
  input  wire logic               i_start,
  input  wire ecpc_pkg::ecpc_resp_t i_resp,
  input  wire logic               i_tx_ready,
  output logic [7:0]              o_tx_byte,
  output logic                    o_tx_valid,
  output logic                    o_busy
);
  import ecpc_pkg::*;

  ecpc_resp_t resp_ff;
  logic       busy_ff;
  logic [4:0] idx_ff;
  logic [7:0] byte_ff;
  logic       valid_ff;
  logic [7:0] acc_ff;

  // ==========================================================================
  // Byte selection
  wire logic       is_ec    = (resp_ff.sub == SUB_EVT_CAP);
  wire logic [4:0] last_idx = is_ec ? TX_EC_LAST : TX_POS_LAST;
  wire logic [4:0] cks_idx  = is_ec ? TX_EC_CKS : TX_POS_CKS;
  wire logic       load     = busy_ff & (~valid_ff | i_tx_ready);
  logic [7:0]      sel_byte;

  always_comb begin
    sel_byte = BYTE_KEEP;
    if (idx_ff == cks_idx) begin
      sel_byte = acc_ff;
    end else if (idx_ff == cks_idx + TX_ONE) begin
      sel_byte = BYTE_DLE;
    end else if (idx_ff == last_idx) begin
      sel_byte = BYTE_ETX;
    end else begin
      unique case (idx_ff)
        5'h00: sel_byte = BYTE_DLE;
        5'h01: sel_byte = BYTE_PKT_ID;
        5'h02: sel_byte = resp_ff.sub;
        5'h03: sel_byte = BYTE_ZERO;
        5'h04: sel_byte = is_ec ? LEN_EC_RESP : LEN_POS_RESP;
        5'h05: sel_byte = MODE_RESP;
        5'h06: sel_byte = is_ec ? {7'h00, resp_ff.cap_en} : {4'h0, resp_ff.mask};
        5'h07: sel_byte = resp_ff.offset[31:24];
        5'h08: sel_byte = resp_ff.offset[23:16];
        5'h09: sel_byte = resp_ff.offset[15:8];
        5'h0a: sel_byte = resp_ff.offset[7:0];
        default: sel_byte = BYTE_KEEP;
      endcase
    end
  end

  // ==========================================================================
  // Sequencer
  wire logic       nxt_busy  = i_start | (busy_ff & ~(load & (idx_ff == last_idx)));
  wire logic       nxt_valid = load | (valid_ff & ~i_tx_ready);
  wire logic [7:0] nxt_acc   = i_start ? BYTE_ZERO :
                               (load && idx_ff != 5'h00 && idx_ff < cks_idx) ? (acc_ff ^ sel_byte) : acc_ff;

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      resp_ff  <= '0;
      busy_ff  <= 1'b0;
      idx_ff   <= 5'h00;
      byte_ff  <= BYTE_ZERO;
      valid_ff <= 1'b0;
      acc_ff   <= BYTE_ZERO;
    end else begin
      if (i_start) resp_ff <= i_resp;
      busy_ff  <= nxt_busy;
      idx_ff   <= i_start ? 5'h00 : (load ? idx_ff + TX_ONE : idx_ff);
      if (load) byte_ff <= sel_byte;
      valid_ff <= nxt_valid;
      acc_ff   <= nxt_acc;
    end
  end

  assign o_tx_byte  = byte_ff;
  assign o_tx_valid = valid_ff;
  assign o_busy     = busy_ff | valid_ff;

  AST_TX_FIRST_DLE: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    i_start |=> ##1 (o_tx_valid && o_tx_byte == BYTE_DLE)) else $error("Response does not open with DLE");
  AST_TX_MODE_RESP: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (load && idx_ff == 5'h05) |=> (o_tx_byte == MODE_RESP)) else $error("Response mode byte wrong");
  AST_TX_HOLD: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (o_tx_valid && !i_tx_ready) |=> (o_tx_valid && $stable(o_tx_byte))) else $error("Stalled byte changed");
endmodule : ecpc_tx
`default_nettype wire

// >>> testbench/ecpc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module ecpc_host_model (
  input  wire logic       i_clk,
  input  wire logic       i_rx_ready,
  input  wire logic [7:0] i_tx_byte,
  input  wire logic       i_tx_valid,
  output var  logic [7:0] o_rx_byte,
  output var  logic       o_rx_valid,
  output var  logic       o_tx_ready
);
  logic [7:0] got_q[$];
  logic       slow;
  int         timeouts;

  initial begin
    o_rx_byte  = 8'h5a;
    o_rx_valid = 1'b0;
    o_tx_ready = 1'b1;
    slow       = 1'b0;
    timeouts   = 0;
  end

  // ==========================================================================
  // Packet builder
  task automatic frame(input logic [7:0] sub, input logic [7:0] mode, input logic [7:0] d[$],
                       input logic bad, output logic [7:0] q[$]);
    logic [7:0]  cks;
    logic [15:0] len;
    len = 16'(d.size() + 2);
    q = '{8'h10, 8'h91, sub, len[15:8], len[7:0], mode};
    q = {q, d};
    cks = 8'h00;
    foreach (q[i]) if (i > 0) cks ^= q[i];
    q.push_back(bad ? ~cks : cks);
    q.push_back(8'h10);
    q.push_back(8'h03);
  endtask : frame

  // ==========================================================================
  // Byte sender: each byte held until taken, then the line shows a changed value
  task automatic send_cmd(input logic [7:0] sub, input logic [7:0] mode, input logic [7:0] d[$],
                          input logic bad);
    logic [7:0] q[$];
    int         n;
    frame(sub, mode, d, bad, q);
    @(posedge i_clk);
    foreach (q[i]) begin
      o_rx_byte  <= q[i];
      o_rx_valid <= 1'b1;
      n = 0;
      do begin
        @(posedge i_clk);
        n++;
      end while (i_rx_ready !== 1'b1 && n < 200);
      if (n >= 200) timeouts++;
    end
    o_rx_valid <= 1'b0;
    o_rx_byte  <= ~q[q.size()-1];
  endtask : send_cmd

  // Receiver, optionally stalling every other cycle
  always @(posedge i_clk) begin
    if (i_tx_valid === 1'b1 && o_tx_ready === 1'b1) got_q.push_back(i_tx_byte);
    o_tx_ready <= slow ? ~o_tx_ready : 1'b1;
  end
endmodule : ecpc_host_model
`default_nettype wire

// >>> testbench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import ecpc_pkg::*;
  logic        i_clk;
  logic        i_reset_n;
  logic [7:0]  rx_byte;
  logic        rx_valid;
  logic        rx_ready;
  logic [7:0]  tx_byte;
  logic        tx_valid;
  logic        tx_ready;
  logic        ev;
  logic [31:0] tns;
  logic        evt_valid;
  ecpc_evt_t   evt;
  logic        cap_en;
  logic [31:0] off_ns;
  logic [3:0]  pos_mask;
  logic [7:0]  nil_q[$];
  int          mismatches;
  int          n_tests;

  ecpc_top dut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_rx_byte(rx_byte), .i_rx_valid(rx_valid),
    .o_rx_ready(rx_ready), .o_tx_byte(tx_byte), .o_tx_valid(tx_valid), .i_tx_ready(tx_ready),
    .i_event(ev), .i_time_ns(tns), .o_evt_valid(evt_valid), .o_evt(evt), .o_capture_en(cap_en),
    .o_offset_ns(off_ns), .o_pos_mask(pos_mask));
  ecpc_host_model host (.i_clk(i_clk), .i_rx_ready(rx_ready), .i_tx_byte(tx_byte),
    .i_tx_valid(tx_valid), .o_rx_byte(rx_byte), .o_rx_valid(rx_valid), .o_tx_ready(tx_ready));

  initial i_clk = 1'b0;
  always #5 i_clk = ~i_clk;

  // ==========================================================================
  // Shared helpers
  task automatic check(input string what, input logic [47:0] seen, input logic [47:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : test_done

  task automatic xact(input logic [7:0] sub, input logic [7:0] mode, input logic [7:0] d[$],
                      input logic bad, input logic [7:0] exp[$]);
    int n;
    host.got_q.delete();
    host.send_cmd(sub, mode, d, bad);
    for (n = 0; n < 100; n++) begin
      @(posedge i_clk);
      #1;
      if (n == 0) check("rx_ready", 48'(rx_ready), 48'(exp.size() == 0));
      if (exp.size() != 0 && host.got_q.size() >= exp.size()) break;
    end
    if (host.timeouts != 0 || (exp.size() != 0 && n == 100)) begin
      mismatches++;
      test_done();
    end
    repeat (3) @(posedge i_clk);
    #1;
    check("resp_len", 48'(host.got_q.size()), 48'(exp.size()));
    foreach (exp[i]) if (i < host.got_q.size()) check("resp_byte", host.got_q[i], exp[i]);
  endtask : xact

  task automatic ec_resp(input logic en, input logic [31:0] off, output logic [7:0] q[$]);
    host.frame(8'h07, 8'h02, '{{7'h00, en}, off[31:24], off[23:16], off[15:8], off[7:0],
               8'hff, 8'hff, 8'hff, 8'hff}, 1'b0, q);
  endtask : ec_resp

  task automatic fire(input logic [31:0] t, input logic exp_hit, input logic [47:0] exp_evt);
    logic hit;
    hit = 1'b0;
    @(posedge i_clk);
    ev  <= 1'b1;
    tns <= t;
    repeat (4) begin
      @(posedge i_clk);
      ev <= 1'b0;
      #1;
      if (evt_valid === 1'b1) hit = 1'b1;
    end
    check("evt_seen", 48'(hit), 48'(exp_hit));
    if (exp_hit) check("evt", evt, exp_evt);
  endtask : fire

  // ==========================================================================
  // Scenarios
  task automatic sc_query();
    logic [7:0] r[$];
    ec_resp(1'b0, 32'h0, r);
    xact(8'h07, 8'h00, nil_q, 1'b0, r);
  endtask : sc_query

  task automatic sc_cap_set();
    logic [7:0] r[$];
    host.slow = 1'b1;
    ec_resp(1'b1, 32'h0000_0005, r);
    xact(8'h07, 8'h01, '{8'h01, 8'h00, 8'h00, 8'h00, 8'h05, 8'hff, 8'haa, 8'hbb, 8'hcc, 8'hdd},
         1'b0, r);
    host.slow = 1'b0;
    check("cap_en", 48'(cap_en), 48'h1);
    check("offset", 48'(off_ns), 48'h5);
  endtask : sc_cap_set

  task automatic sc_event();
    fire(32'hffff_fffe, 1'b1, {32'h0000_0003, 16'h0001});
    fire(32'h0000_0100, 1'b1, {32'h0000_0105, 16'h0002});
  endtask : sc_event

  task automatic sc_keep();
    logic [7:0] r[$];
    ec_resp(1'b1, 32'h0000_0005, r);
    xact(8'h07, 8'h01, '{8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00},
         1'b0, r);
    fire(32'h0000_0010, 1'b1, {32'h0000_0015, 16'h0001});
    ec_resp(1'b0, 32'h0000_0005, r);
    xact(8'h07, 8'h01, '{8'h00, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00},
         1'b0, r);
    fire(32'h0000_0020, 1'b0, 48'h0);
  endtask : sc_keep

  task automatic sc_pos();
    logic [7:0] r[$];
    for (int m = 0; m < 16; m++) begin
      host.frame(8'h08, 8'h02, '{8'(m)}, 1'b0, r);
      xact(8'h08, 8'h01, '{8'(m)}, 1'b0, r);
      check("pos_mask", 48'(pos_mask), 48'(m));
    end
    xact(8'h08, 8'h00, nil_q, 1'b0, r);
  endtask : sc_pos

  task automatic sc_bad();
    logic [7:0] r[$];
    xact(8'h07, 8'h01, '{8'h01, 8'h00, 8'h00, 8'h00, 8'h09, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00},
         1'b1, nil_q);
    xact(8'h09, 8'h00, nil_q, 1'b0, nil_q);
    xact(8'h08, 8'h02, '{8'h03}, 1'b0, nil_q);
    xact(8'h08, 8'h03, '{8'h03}, 1'b0, nil_q);
    xact(8'h07, 8'h00, '{8'h01}, 1'b0, nil_q);
    xact(8'h08, 8'h01, '{8'h13}, 1'b0, nil_q);
    xact(8'h07, 8'h01, '{8'h01, 8'h00, 8'h00, 8'h00, 8'h09, 8'hff, 8'h00, 8'h00, 8'h00}, 1'b0, nil_q);
    check("cap_en", 48'(cap_en), 48'h0);
    check("offset", 48'(off_ns), 48'h5);
    check("pos_mask", 48'(pos_mask), 48'hf);
    ec_resp(1'b0, 32'h0000_0005, r);
    xact(8'h07, 8'h00, nil_q, 1'b0, r);
  endtask : sc_bad

  initial begin
    mismatches = 0;
    n_tests    = 0;
    i_reset_n  = 1'b0;
    ev         = 1'b0;
    tns        = 32'h0;
    repeat (12) @(posedge i_clk);
    i_reset_n <= 1'b1;
    sc_query();
    sc_cap_set();
    sc_event();
    sc_keep();
    sc_pos();
    sc_bad();
    test_done();
  end
endmodule : tb_top
`default_nettype wire
